// File: design/wwd_pkg.sv
// package: constants for the windowed watchdog control block
package wwd_pkg;
  // config word bit positions
  localparam int unsigned WINDOW_DISABLE_CFG_BIT = 6;
  // reset control register bit positions
  localparam int unsigned SOFT_ENABLE_BIT = 5;
  localparam int unsigned TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned RCR_WIDTH = 16;
  localparam logic [15:0] RCR_RESET = 16'h0000;
  // time base tick period in ns and derived divider count
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_CYCLES =
    (TICK_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 : TICK_PERIOD_NS / CLK_PERIOD_NS;
  // watchdog period in ticks
  localparam int unsigned PERIOD_TICKS = 1024;
  // reset pulse length in clock cycles
  localparam int unsigned RESET_PULSE_CYCLES = 4;
endpackage : wwd_pkg

// File: design/wwd_control.sv
// module: watchdog enable, clear window and timeout control
//
// Operation
// - in window mode a clear restarts the count only in the final quarter
// - in window mode an early clear causes a watchdog reset like a timeout
// - window mode is on only when config word one bit 6 is zero
// - fuse enable set keeps the watchdog always running
// - fuse enable zero lets the soft enable bit 5 control the watchdog
// - every device reset clears the soft enable bit
// - fuse enable one ignores the soft enable bit
// - software writes to reset flags never cause a device reset
`timescale 1ns/100ps
module wwd_control #(
  parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYCLES,
  parameter int unsigned PERIOD_TICKS = wwd_pkg::PERIOD_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] config_word_one,
  input wire logic watchdog_fuse_enable,
  input wire logic clear_watchdog_instr,
  input wire logic device_reset,
  input wire logic rcr_write,
  input wire logic [15:0] rcr_wdata,
  output logic [15:0] reset_control_reg,
  output logic watchdog_running,
  output logic watchdog_reset_req,
  output logic window_open,
  output logic [31:0] watchdog_timer
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned PW = 32;
  localparam logic [PW-1:0] LAST_TICK = PW'(PERIOD_TICKS - 1);
  localparam logic [PW-1:0] WIN_START = PW'(PERIOD_TICKS - PERIOD_TICKS / 4);
  localparam logic [CW-1:0] DIV_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [2:0] PULSE_LAST = 3'(wwd_pkg::RESET_PULSE_CYCLES - 1);

  logic [CW-1:0] div_q;
  logic tick;
  logic window_mode;
  logic enabled;
  logic in_window;
  logic clear_ok;
  logic clear_early;
  logic expire;
  logic fire;
  logic [2:0] pulse_q;
  logic pulse_active_q;

  // ----------------------------------------
  // enable and mode decode
  // ----------------------------------------
  assign window_mode = ~config_word_one[wwd_pkg::WINDOW_DISABLE_CFG_BIT];
  assign enabled = watchdog_fuse_enable
    | reset_control_reg[wwd_pkg::SOFT_ENABLE_BIT];
  assign in_window = watchdog_timer >= WIN_START;
  assign clear_ok = clear_watchdog_instr & enabled & (~window_mode | in_window);
  assign clear_early = clear_watchdog_instr & enabled & window_mode & ~in_window;
  assign expire = enabled & tick & (watchdog_timer == LAST_TICK);
  // an accepted clear on the expiry edge restarts the count instead of firing
  assign fire = (expire & ~clear_ok) | clear_early;

  // ----------------------------------------
  // time base divider
  // ----------------------------------------
  assign tick = enabled & (div_q == DIV_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (!enabled || clear_ok || fire || div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CW'(1);
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_timer <= '0;
    end else if (!enabled || clear_ok || fire || device_reset) begin
      watchdog_timer <= '0;
    end else if (tick) begin
      watchdog_timer <= watchdog_timer + PW'(1);
    end
  end

  // ----------------------------------------
  // reset control register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_control_reg <= wwd_pkg::RCR_RESET;
    end else begin
      if (rcr_write) begin
        reset_control_reg <= rcr_wdata;
      end
      if (device_reset || pulse_active_q) begin
        reset_control_reg[wwd_pkg::SOFT_ENABLE_BIT] <= 1'b0;
      end
      if (fire) begin
        reset_control_reg[wwd_pkg::TIMEOUT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // watchdog reset pulse
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_active_q <= 1'b0;
      pulse_q <= '0;
    end else if (fire) begin
      pulse_active_q <= 1'b1;
      pulse_q <= '0;
    end else if (pulse_active_q) begin
      pulse_q <= pulse_q + 3'd1;
      if (pulse_q == PULSE_LAST) begin
        pulse_active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_reset_req <= 1'b0;
      watchdog_running <= 1'b0;
      window_open <= 1'b0;
    end else begin
      watchdog_reset_req <= fire | (pulse_active_q & (pulse_q != PULSE_LAST));
      watchdog_running <= enabled;
      window_open <= enabled & window_mode & in_window;
    end
  end
endmodule : wwd_control

// File: tb/wwd_control_sva.sv
// checker for the watchdog control ports
`timescale 1ns/100ps
module wwd_control_sva #(parameter int unsigned PERIOD_TICKS = 8) (input wire logic sys_clk,
  input wire logic rst_n, watchdog_fuse_enable, clear_watchdog_instr, device_reset, rcr_write,
  input wire logic watchdog_running, watchdog_reset_req, input wire logic [31:0] watchdog_timer,
  input wire logic [15:0] config_word_one, rcr_wdata, reset_control_reg);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire en = watchdog_fuse_enable || reset_control_reg[5];
  wire clr = clear_watchdog_instr && en && !watchdog_reset_req;
  wire early = !config_word_one[6] && watchdog_timer < PERIOD_TICKS - PERIOD_TICKS / 4;
  sequence s_pl; watchdog_reset_req [*4] ##1 !watchdog_reset_req; endsequence
  property p_fu; $past(rst_n) && $past(watchdog_fuse_enable) |-> watchdog_running; endproperty
  a_fu: assert property (p_fu) else $error("fuse");
  property p_sw; $past(rst_n) && !$past(watchdog_fuse_enable) |->
    watchdog_running == $past(reset_control_reg[5]); endproperty
  a_sw: assert property (p_sw) else $error("soft");
  property p_dr; device_reset |=> !reset_control_reg[5]; endproperty
  a_dr: assert property (p_dr) else $error("devrst");
  property p_pl; $rose(watchdog_reset_req) |-> s_pl; endproperty
  a_pl: assert property (p_pl) else $error("pulse");
  property p_fl; $rose(watchdog_reset_req) |-> reset_control_reg[4]; endproperty
  a_fl: assert property (p_fl) else $error("flag");
  property p_ea; clr && early |=> watchdog_reset_req; endproperty
  a_ea: assert property (p_ea) else $error("early");
  property p_ok; clr && !early |=> watchdog_timer == 0 && !watchdog_reset_req; endproperty
  a_ok: assert property (p_ok) else $error("clear");
  property p_wr; rcr_write |=> reset_control_reg[15:6] == $past(rcr_wdata[15:6]); endproperty
  a_wr: assert property (p_wr) else $error("write");
endmodule : wwd_control_sva

// File: tb/wwd_core_model.sv
// core model: issues a clear instruction one cycle after a kick
`timescale 1ns/100ps
module wwd_core_model (input wire logic sys_clk, input wire logic kick, output logic clr);
  always_ff @(posedge sys_clk) clr <= kick;
endmodule : wwd_core_model

// File: tb/wwd_control_tb.sv
// bench for the watchdog control block
`timescale 1ns/100ps
module wwd_control_tb;
  logic sys_clk = 0, rst_n = 0, fu = 0, dv = 0, wr = 0, kk = 0, clr, run, req, win;
  logic [15:0] cfg = 16'h0040, wd = 16'h0000, rcr;
  logic [31:0] tmr;
  int err_count = 0, n_tests = 0, ex;
  initial forever #10 sys_clk = ~sys_clk;
  wwd_core_model i_core (.sys_clk(sys_clk), .kick(kk), .clr(clr));
  wwd_control #(.TICK_CYCLES(4), .PERIOD_TICKS(8)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .config_word_one(cfg), .watchdog_fuse_enable(fu), .clear_watchdog_instr(clr),
    .device_reset(dv), .rcr_write(wr), .rcr_wdata(wd), .reset_control_reg(rcr),
    .watchdog_running(run), .watchdog_reset_req(req), .window_open(win), .watchdog_timer(tmr));
  task automatic ck(input logic [31:0] s, input logic [31:0] e, input string n);
    n_tests++;
    if (s !== e) begin err_count++; $display("[ERR] %s exp %h seen %h", n, e, s); end
  endtask : ck
  task automatic finish_test(input int h);
    if (err_count + h == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic w(input logic [15:0] d);
    repeat (6) @(posedge sys_clk);
    wd <= d; wr <= 1'b1; ex = d;
    @(posedge sys_clk) wr <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : w
  task automatic kc; @(posedge sys_clk) kk <= 1'b1; @(posedge sys_clk) kk <= 1'b0; endtask : kc
  task automatic hi(ref logic s);
    repeat (99) if (s !== 1'b1) @(negedge sys_clk);
    if (s !== 1'b1) finish_test(1);
  endtask : hi
  initial begin
    ex = $urandom(27);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    w(16'($urandom) & 16'hffcf | 16'h0020);
    ck(rcr, ex, "rcr");
    ck(run, 1, "run");
    kc; repeat (3) @(negedge sys_clk);
    ck(req, 0, "nowin");
    hi(req); @(negedge sys_clk) ck(rcr[5:4], 1, "flags");
    @(posedge sys_clk) cfg <= 16'h0000;
    w(16'h0020); kc; repeat (2) @(negedge sys_clk);
    ck(req, 1, "early");
    ck(rcr[4], 1, "eflag");
    w(16'h0020); hi(win); kc; repeat (3) @(negedge sys_clk) ck(req, 0, "req");
    ck(tmr, 0, "restart");
    @(posedge sys_clk) fu <= 1'b1;
    w(16'h0020); @(posedge sys_clk) dv <= 1'b1; @(posedge sys_clk) dv <= 1'b0;
    @(negedge sys_clk) ck({rcr[5], run}, 1, "soft");
    finish_test(0);
  end
endmodule : wwd_control_tb
bind wwd_control wwd_control_sva #(.PERIOD_TICKS(PERIOD_TICKS)) i_sva (.sys_clk(sys_clk),
  .rst_n(rst_n), .watchdog_fuse_enable(watchdog_fuse_enable),
  .clear_watchdog_instr(clear_watchdog_instr), .device_reset(device_reset),
  .rcr_write(rcr_write), .watchdog_running(watchdog_running),
  .watchdog_reset_req(watchdog_reset_req), .watchdog_timer(watchdog_timer),
  .config_word_one(config_word_one), .rcr_wdata(rcr_wdata),
  .reset_control_reg(reset_control_reg));
